//--- design/phy_sideband.sv
// Per-port PHY sideband pins with a small register file and management pin control
//
// The implementer's own choices: the placing of the registers and strobed register access.
`include "phy_sideband_cfg.svh"
`default_nettype none
module phy_sideband #(
	parameter int PORTS = 2
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [`SB_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [PORTS-1:0] loopback,
	output logic [PORTS-1:0] lock_ref_n,
	output logic [PORTS-1:0] comma_en,
	input wire logic [PORTS-1:0] comma_det,
	input wire logic mgmt_clk_in,
	output logic mgmt_clk_out,
	output logic mgmt_clk_oe_n,
	input wire logic mgmt_dat_in,
	output logic mgmt_dat_out,
	output logic mgmt_dat_oe_n
);
	import phy_sideband_pkg::*;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

	port_ctl_t ctl_q [PORTS];
	port_mode_t mode_q [PORTS];
	logic [3:0] macc_q;
	logic [31:0] rdata_d;
	rd_state_t rd_state_q;
	logic [PORTS-1:0] comma_s;
	logic mgmt_clk_s;
	logic mgmt_dat_s;
	logic [PORTS-1:0] loopback_d;
	logic [PORTS-1:0] lock_ref_n_d;
	logic [PORTS-1:0] comma_en_d;

	// Shared-register selects, named once for the write path, the read mux and the checks
	wire macc_sel = (addr == `SB_OFF_MACC);
	wire stat_sel = (addr == `SB_OFF_STAT);
	wire macc_we = wr && macc_sel;

	// Address of a port's control or mode register
	// Only two ports decode; a larger PORTS would alias onto the second port's offsets
	function automatic logic [`SB_ADDR_W-1:0] ctl_off(input int p);
		ctl_off = (p == 0) ? `SB_OFF_CTL0 : `SB_OFF_CTL1;
	endfunction : ctl_off

	function automatic logic [`SB_ADDR_W-1:0] mode_off(input int p);
		mode_off = (p == 0) ? `SB_OFF_MODE0 : `SB_OFF_MODE1;
	endfunction : mode_off

	// Pins from outside pass two flops before use
	sync2 #(.W(PORTS + 2)) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in({mgmt_dat_in, mgmt_clk_in, comma_det}),
		.sync_out({mgmt_dat_s, mgmt_clk_s, comma_s})
	);

	// Per-port register write decode
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		wire ctl_we = wr && (addr == ctl_off(p));
		wire mode_we = wr && (addr == mode_off(p));

		always_ff @(posedge clock) begin
			if (!reset_n) begin
				ctl_q[p] <= `SB_CTL_RST;
				mode_q[p] <= `SB_MODE_RST;
			end else begin
				if (ctl_we) begin
					ctl_q[p] <= port_ctl_t'(wdata[1:0]);
				end
				if (mode_we) begin
					mode_q[p] <= port_mode_t'(wdata[1:0]);
				end
			end
		end

		// Next pin levels of this port as one word; held inactive outside ten-bit mode
		port_pins_t pins_d;
		assign pins_d = '{
			loopback: mode_q[p].pcs_mode & ctl_q[p].loopback_ctl_bit,
			lock_ref_n: ~(mode_q[p].pcs_mode & mode_q[p].lock_en),
			comma_en: mode_q[p].pcs_mode & ctl_q[p].encdet
		};
		assign loopback_d[p] = pins_d.loopback;
		assign lock_ref_n_d[p] = pins_d.lock_ref_n;
		assign comma_en_d[p] = pins_d.comma_en;
	end

	// Management access register steers both two-way pins
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			macc_q <= `SB_MACC_RST;
		end else if (macc_we) begin
			macc_q <= wdata[3:0];
		end
	end

	// Outputs registered one stage after the control bits, so they move the edge after a write
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			loopback <= '0;
			lock_ref_n <= '1;
			comma_en <= '0;
			mgmt_clk_out <= 1'b0;
			mgmt_clk_oe_n <= 1'b0;
			mgmt_dat_out <= 1'b0;
			mgmt_dat_oe_n <= 1'b1;
		end else begin
			loopback <= loopback_d;
			lock_ref_n <= lock_ref_n_d;
			comma_en <= comma_en_d;
			mgmt_clk_out <= macc_q[`SB_MACC_CLK_OUT_BIT];
			mgmt_clk_oe_n <= ~macc_q[`SB_MACC_CLK_OE_BIT];
			mgmt_dat_out <= macc_q[`SB_MACC_DAT_OUT_BIT];
			mgmt_dat_oe_n <= ~macc_q[`SB_MACC_DAT_OE_BIT];
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb begin
		rdata_d = 32'h0;
		for (int p = 0; p < PORTS; p++) begin
			if (addr == ctl_off(p)) begin
				rdata_d = {30'h0, ctl_q[p]};
			end
			if (addr == mode_off(p)) begin
				rdata_d = {30'h0, mode_q[p]};
			end
		end
		if (macc_sel) begin
			rdata_d = {26'h0, mgmt_dat_s, mgmt_clk_s, macc_q};
		end
		if (stat_sel) begin
			rdata_d = {{(32 - PORTS){1'b0}}, comma_s};
		end
	end

	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rd_state_q <= RD_IDLE;
			rdata <= 32'h0;
		end else begin
			case (rd_state_q)
				RD_IDLE, RD_DATA: begin
					rd_state_q <= rd ? RD_DATA : RD_IDLE;
					rdata <= rd ? rdata_d : 32'h0;
				end
				default: begin
					rd_state_q <= RD_IDLE;
					rdata <= 32'h0;
				end
			endcase
		end
	end

	// Checks: each per-port sideband pin against its next value one edge earlier,
	// which also catches a pin stuck at either level
	a_loop_follows: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1
		|=> loopback == $past(loopback_d))
		else $error("loopback did not follow control");

	// Lock-to-reference pins track their decode the same way
	a_lock_follows: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1
		|=> lock_ref_n == $past(lock_ref_n_d))
		else $error("lock_ref_n mismatch");

	// Comma-detect enables track their decode the same way
	a_comma_follows: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1
		|=> comma_en == $past(comma_en_d))
		else $error("comma_en did not follow control");

	// Clock pin drives 0 straight out of reset
	a_clk_default: assert property (@(posedge clock)
		!reset_n
		|=> mgmt_clk_out == 1'b0 && mgmt_clk_oe_n == 1'b0)
		else $error("mgmt clock not driving 0 after reset");

	// Data pin released out of reset, so the board pull-up holds the line
	a_dat_default: assert property (@(posedge clock)
		!reset_n
		|=> mgmt_dat_oe_n == 1'b1 && mgmt_dat_out == 1'b0)
		else $error("mgmt data not released after reset");

	// Sideband pins sit at their inactive levels through reset
	a_reset_vals: assert property (@(posedge clock)
		!reset_n
		|=> loopback == '0 && lock_ref_n == '1 && comma_en == '0)
		else $error("sideband not at reset value");

	// Access register writes reach the pins two edges later: register, then pin flop.
	// Checked from wdata, not from the register, so a dead register is caught too
	a_clk_oe_bit: assert property (@(posedge clock) disable iff (!reset_n)
		macc_we
		|=> ##1 mgmt_clk_oe_n == !$past(wdata[`SB_MACC_CLK_OE_BIT], 2))
		else $error("mgmt clock enable not from register");

	// Clock pin level as a general purpose output
	a_clk_gp: assert property (@(posedge clock) disable iff (!reset_n)
		macc_we
		|=> ##1 mgmt_clk_out == $past(wdata[`SB_MACC_CLK_OUT_BIT], 2))
		else $error("mgmt clock level not from register");

	// Data pin enable as a general purpose pin
	a_dat_gp: assert property (@(posedge clock) disable iff (!reset_n)
		macc_we
		|=> ##1 mgmt_dat_oe_n == !$past(wdata[`SB_MACC_DAT_OE_BIT], 2))
		else $error("mgmt data enable not from register");

	// Data pin level as a general purpose pin
	a_dat_level: assert property (@(posedge clock) disable iff (!reset_n)
		macc_we
		|=> ##1 mgmt_dat_out == $past(wdata[`SB_MACC_DAT_OUT_BIT], 2))
		else $error("mgmt data level not from register");

	// No write for two edges, so no sideband pin may move
	a_out_stable: assert property (@(posedge clock) disable iff (!reset_n)
		!wr ##1 !wr
		|=> $stable(loopback) && $stable(lock_ref_n) && $stable(comma_en))
		else $error("sideband moved without a write");

	// Read data stands only in the cycle after a read strobe
	a_rd_one: assert property (@(posedge clock) disable iff (!reset_n)
		!rd
		|=> rdata == 32'h0)
		else $error("read data outside its cycle");

	// Unmapped offsets read as zero
	a_rd_unmapped: assert property (@(posedge clock) disable iff (!reset_n)
		rd && !(addr inside {`SB_OFF_CTL0, `SB_OFF_CTL1, `SB_OFF_MODE0, `SB_OFF_MODE1,
			`SB_OFF_MACC, `SB_OFF_STAT})
		|=> rdata == 32'h0)
		else $error("unmapped offset returned data");

	// Every register is narrow, so the upper read bits never carry anything
	a_rd_narrow: assert property (@(posedge clock) disable iff (!reset_n)
		rd
		|=> rdata[31:6] == 26'h0)
		else $error("upper read bits not zero");

	// Per-port checks, the first three taken from the write that sets the controlling bit
	for (genvar p = 0; p < PORTS; p++) begin : g_chk
		wire port_we = wr && (addr == ctl_off(p) || addr == mode_off(p));

		// Loopback takes the written bit two edges later while in ten-bit mode
		a_loop_write: assert property (@(posedge clock) disable iff (!reset_n)
			wr && addr == ctl_off(p) && mode_q[p].pcs_mode
			|=> ##1 loopback[p] == $past(wdata[`SB_CTL_LOOPBACK_CTL_BIT_BIT], 2))
			else $error("loopback did not take the written bit");

		// Lock-to-reference goes low only with both mode bits written high
		a_lock_write: assert property (@(posedge clock) disable iff (!reset_n)
			wr && addr == mode_off(p)
			|=> ##1 lock_ref_n[p] == !($past(wdata[`SB_MODE_LOCK_ENABLE_BIT_BIT], 2)
				&& $past(wdata[`SB_MODE_PCS_BIT], 2)))
			else $error("lock_ref_n did not take the written bits");

		// Comma-detect enable takes the written bit while in ten-bit mode
		a_comma_write: assert property (@(posedge clock) disable iff (!reset_n)
			wr && addr == ctl_off(p) && mode_q[p].pcs_mode
			|=> ##1 comma_en[p] == $past(wdata[`SB_CTL_ENCDET_BIT], 2))
			else $error("comma_en did not take the written bit");

		// Outside ten-bit mode every sideband pin of the port stays inactive
		a_pcs_gate: assert property (@(posedge clock) disable iff (!reset_n)
			!mode_q[p].pcs_mode
			|=> !loopback[p] && lock_ref_n[p] && !comma_en[p])
			else $error("sideband active outside ten-bit mode");

		// Without a write to this port for two edges its pins hold
		a_port_hold: assert property (@(posedge clock) disable iff (!reset_n)
			!port_we ##1 !port_we
			|=> $stable(loopback[p]) && $stable(lock_ref_n[p]) && $stable(comma_en[p]))
			else $error("port sideband moved without a write");
	end

	// Main scenarios worth seeing at least once
	c_loop_on: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(loopback[0]));
	c_lock_on: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(lock_ref_n[1]));
	c_gp_out: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(mgmt_dat_oe_n));
	c_comma_on: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(comma_en[1]));
	c_clk_free: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(mgmt_clk_oe_n));
endmodule : phy_sideband
`default_nettype wire

//--- design/phy_sideband_cfg.svh
// Register offsets, field positions and reset values for the sideband block
`ifndef PHY_SIDEBAND_CFG_SVH
`define PHY_SIDEBAND_CFG_SVH

`define SB_ADDR_W 4
// Register offsets (word index = byte address here)
`define SB_OFF_CTL0 4'h0
`define SB_OFF_CTL1 4'h4
`define SB_OFF_MODE0 4'h8
`define SB_OFF_MODE1 4'hC
`define SB_OFF_MACC 4'h1
`define SB_OFF_STAT 4'h2

// Port management control register fields
`define SB_CTL_LOOPBACK_CTL_BIT_BIT 0
`define SB_CTL_ENCDET_BIT 1
// Port mode register fields
`define SB_MODE_LOCK_ENABLE_BIT_BIT 0
`define SB_MODE_PCS_BIT 1
// Management access register fields
`define SB_MACC_CLK_OUT_BIT 0
`define SB_MACC_CLK_OE_BIT 1
`define SB_MACC_DAT_OUT_BIT 2
`define SB_MACC_DAT_OE_BIT 3
`define SB_MACC_CLK_IN_BIT 4
`define SB_MACC_DAT_IN_BIT 5
// Status register fields
`define SB_STAT_COMMA0_BIT 0
`define SB_STAT_COMMA1_BIT 1

// Reset values
`define SB_CTL_RST 2'h0
`define SB_MODE_RST 2'h2
`define SB_MACC_RST 4'h2

`endif

//--- design/phy_sideband_pkg.sv
// Types shared by the sideband control block
`default_nettype none
package phy_sideband_pkg;
	// Per-port control bits as software sees them
	typedef struct packed {
		logic encdet;
		logic loopback_ctl_bit;
	} port_ctl_t;

	// Per-port mode bits
	typedef struct packed {
		logic pcs_mode;
		logic lock_en;
	} port_mode_t;

	// Sideband outputs of one port toward the PHY
	typedef struct packed {
		logic loopback;
		logic lock_ref_n;
		logic comma_en;
	} port_pins_t;

	// Two-signal view of a two-way pin: level and active-low enable
	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drive_t;
endpackage : phy_sideband_pkg
`default_nettype wire

//--- design/sync2.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : sync2
`default_nettype wire

//--- tb/phy_model.sv
// Behavioural PHY at the far side of the sideband pins
`default_nettype none
module phy_model #(
	parameter int PORTS = 2
) (
	input wire logic clock,
	input wire logic [PORTS-1:0] loopback,
	input wire logic [PORTS-1:0] lock_ref_n,
	input wire logic [PORTS-1:0] comma_en,
	input wire logic [PORTS-1:0] comma_seen,
	output logic [PORTS-1:0] comma_det
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [PORTS-1:0] wrapped;
	logic [PORTS-1:0] ref_locked;
	logic [PORTS-1:0] aligned_q = '0;
	// Wrap and lock are levels only; no serial link is modelled
	assign wrapped = loopback;
	assign ref_locked = ~lock_ref_n;
	// Flag follows the data presented right now
	assign comma_det = comma_seen;
	// Realign while searching, otherwise keep the old boundary
	always @(posedge clock) begin
		aligned_q <= (comma_en & comma_seen) | (~comma_en & aligned_q);
	end
endmodule : phy_model
`default_nettype wire

//--- tb/phy_sideband_test.sv
// Self-checking bench for the PHY sideband block
`include "phy_sideband_cfg.svh"
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
`default_nettype none
module phy_sideband_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic reset_n = 0;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 0;
	logic rd = 0;
	logic [31:0] rdata;
	logic [1:0] loopback, lock_ref_n, comma_en, comma_det;
	logic [1:0] comma_seen = '0;
	logic clk_out, clk_oe_n, dat_out, dat_oe_n, clk_pin, dat_pin;
	int fail_count = 0;
	int check_count = 0;
	int ctl[2], mode[2], macc;
	bit [31:0] seed = 32'h91E29395;
	logic [3:0] offs[6] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1, 4'h2};
	// Both management pins carry pull-ups when released
	assign clk_pin = clk_oe_n ? 1'b1 : clk_out;
	assign dat_pin = dat_oe_n ? 1'b1 : dat_out;
	always #25 clock = ~clock;
	phy_sideband #(.PORTS(2)) u_dut (.clock(clock), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .loopback(loopback),
		.lock_ref_n(lock_ref_n), .comma_en(comma_en), .comma_det(comma_det),
		.mgmt_clk_in(clk_pin), .mgmt_clk_out(clk_out), .mgmt_clk_oe_n(clk_oe_n),
		.mgmt_dat_in(dat_pin), .mgmt_dat_out(dat_out), .mgmt_dat_oe_n(dat_oe_n));
	phy_model #(.PORTS(2)) u_phy (.clock(clock), .loopback(loopback),
		.lock_ref_n(lock_ref_n), .comma_en(comma_en), .comma_seen(comma_seen),
		.comma_det(comma_det));
	function automatic bit [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Reference read value; status waits long enough for the synchroniser
	function automatic logic [31:0] exp_rd(input int a);
		case (a)
			0, 4: return ctl[a / 4];
			8, 12: return mode[a / 4 - 2];
			1: return macc | ((macc[1] ? macc[0] : 1) << 4) | ((macc[3] ? macc[2] : 1) << 5);
			2: return comma_seen;
			default: return 0;
		endcase
	endfunction : exp_rd
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clock);
		wr <= 0;
		case (a)
			0, 4: ctl[a / 4] = d & 3;
			8, 12: mode[a / 4 - 2] = d & 3;
			1: macc = d & 15;
			default: ;
		endcase
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1;
		@(posedge clock);
		rd <= 0;
		#1 `CHK("rdata", exp_rd(a), rdata)
	endtask : rd_chk
	// Pins settle the edge after the write is taken; the check waits two edges
	task automatic pins_chk();
		logic [1:0] el, er, ec;
		repeat (2) @(posedge clock);
		#1;
		for (int p = 0; p < 2; p++) begin
			el[p] = ctl[p][0] & mode[p][1];
			er[p] = !(mode[p][0] & mode[p][1]);
			ec[p] = ctl[p][1] & mode[p][1];
		end
		`CHK("loopback", el, loopback)
		`CHK("lock_ref_n", er, lock_ref_n)
		`CHK("comma_en", ec, comma_en)
		`CHK("mgmt_clk_oe_n", ~macc[1], clk_oe_n)
		`CHK("mgmt_clk_out", macc[0], clk_out)
		`CHK("mgmt_dat", {macc[2], ~macc[3]}, {dat_out, dat_oe_n})
	endtask : pins_chk
	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	// Main sequence: reset values, random traffic, refused accesses
	initial begin
		ctl = '{`SB_CTL_RST, `SB_CTL_RST};
		mode = '{`SB_MODE_RST, `SB_MODE_RST};
		macc = `SB_MACC_RST;
		repeat (10) @(posedge clock);
		reset_n <= 1;
		pins_chk();
		for (int i = 0; i < 60; i++) begin
			@(posedge clock) comma_seen <= 2'(xs());
			wr_reg(offs[xs() % 6], xs());
			pins_chk();
			rd_chk(offs[xs() % 6]);
		end
		wr_reg(4'h3, xs());
		foreach (offs[k]) rd_chk(offs[k]);
		rd_chk(4'h3);
		report_and_stop();
	end
	// Hang guard well past the expected run length
	initial begin
		#(50 * 20000);
		fail_count++;
		report_and_stop();
	end
endmodule : phy_sideband_test
`default_nettype wire
